// [hdl/exec_params.svh]
// Overview of operation
// RQ1 - store_accumulator copies the accumulator into the file register named by its 7-bit operand, flags untouched, one cycle.
// RQ2 - load_literal puts its 8-bit immediate into the accumulator in one cycle with no flag change; unused bits are zero.
// RQ3 - interrupt_exit pops the return stack into the program counter and leaves flags alone.
// RQ4 - interrupt_exit sets global_irq_enable at bit 7 of irq_control_reg and takes two cycles.
// RQ5 - literal_return loads its immediate into the accumulator and the stack top into the program counter, flags unchanged.
// RQ6 - literal_return is one word and two cycles since the popped address replaces the sequential fetch.
// RQ7 - plain return pops the stack top into the program counter in two cycles, accumulator and flags unchanged.
// RQ8 - no_operation is one word and one cycle and only advances the program counter.
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
`define OPC_NO_OPERATION 14'h0000
`define OPC_RETURN 14'h0008
`define OPC_INTERRUPT_EXIT 14'h0009
`define OPC_STORE_HI 7'h01
`define OPC_LOAD_HI 4'hc
`define OPC_LITRET_HI 4'hd
`define IRQ_ENABLE_BIT 7
`define ACC_RESET 8'h00
`define PROG_COUNT_RESET 13'h0000
`endif

// [hdl/exec_pkg.sv]
package exec_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_NO_OPERATION = 3'h1,
        OP_STORE = 3'h2,
        OP_LOAD = 3'h3,
        OP_RET = 3'h4,
        OP_LITRET = 3'h5,
        OP_IRET = 3'h6
    } op_t;
    typedef struct packed {
        op_t op;
        logic [6:0] addr;
        logic [7:0] lit;
    } dec_t;
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } fwrite_t;
endpackage : exec_pkg

// [hdl/instr_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "exec_params.svh"
module instr_decode
    import exec_pkg::*;
(
    input wire logic [13:0] i_word,
    output var exec_pkg::dec_t o_dec
);
    always_comb begin
        o_dec.addr = i_word[6:0];
        o_dec.lit = i_word[7:0];
        if (i_word == `OPC_NO_OPERATION) begin
            o_dec.op = OP_NO_OPERATION;
        end else if (i_word == `OPC_RETURN) begin
            o_dec.op = OP_RET;
        end else if (i_word == `OPC_INTERRUPT_EXIT) begin
            o_dec.op = OP_IRET;
        end else if (i_word[13:7] == `OPC_STORE_HI) begin
            o_dec.op = OP_STORE;
        end else if (i_word[13:10] == `OPC_LOAD_HI && i_word[9:8] == 2'h0) begin
            o_dec.op = OP_LOAD; // see RQ2
        end else if (i_word[13:10] == `OPC_LITRET_HI && i_word[9:8] == 2'h0) begin
            o_dec.op = OP_LITRET;
        end else begin
            o_dec.op = OP_NONE;
        end
    end
endmodule : instr_decode
`default_nettype wire

// [hdl/move_and_return_instruction_exec.sv]
`timescale 1ns/1ps
`default_nettype none
`include "exec_params.svh"
module move_and_return_instruction_exec
    import exec_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic [13:0] i_word,
    input wire logic [12:0] i_stack_top,
    input wire logic [7:0] i_irq_control,
    output logic [7:0] o_acc,
    output logic [12:0] o_program_counter,
    output logic o_busy,
    output logic o_pop,
    output logic o_file_we,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_data,
    output logic o_irq_control_we,
    output logic [7:0] o_irq_control,
    output logic o_flush
);
    // ****************************************
    // decode
    // ****************************************
    dec_t dec;
    instr_decode u_dec (
        .i_word(i_word),
        .o_dec(dec)
    );

    // ****************************************
    // execute
    // ****************************************
    logic [7:0] next_acc;
    logic [12:0] next_prog_count;
    logic next_busy;
    logic next_pop;
    fwrite_t next_fw;
    logic next_icw;
    logic [7:0] next_ic;
    logic next_flush;
    logic take;
    assign take = i_valid && !o_busy;

    always_comb begin
        next_acc = o_acc;
        next_prog_count = o_program_counter;
        next_busy = 1'b0;
        next_pop = 1'b0;
        next_fw = '0;
        next_icw = 1'b0;
        next_ic = i_irq_control;
        next_flush = 1'b0;
        if (take) begin
            next_prog_count = o_program_counter + 13'h0001; // see RQ8
            unique case (dec.op)
                OP_STORE: begin
                    next_fw.we = 1'b1; // see RQ1
                    next_fw.addr = dec.addr;
                    next_fw.data = o_acc;
                end
                OP_LOAD: begin
                    next_acc = dec.lit; // see RQ2
                end
                OP_RET: begin
                    next_prog_count = i_stack_top; // see RQ7
                    next_pop = 1'b1;
                    next_busy = 1'b1;
                    next_flush = 1'b1;
                end
                OP_LITRET: begin
                    next_acc = dec.lit; // see RQ5
                    next_prog_count = i_stack_top;
                    next_pop = 1'b1;
                    next_busy = 1'b1; // see RQ6
                    next_flush = 1'b1;
                end
                OP_IRET: begin
                    next_prog_count = i_stack_top; // see RQ3
                    next_pop = 1'b1;
                    next_busy = 1'b1;
                    next_flush = 1'b1;
                    next_icw = 1'b1; // see RQ4
                    next_ic[`IRQ_ENABLE_BIT] = 1'b1;
                end
                OP_NO_OPERATION, OP_NONE: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_acc <= `ACC_RESET;
            o_program_counter <= `PROG_COUNT_RESET;
            o_busy <= 1'b0;
            o_pop <= 1'b0;
            o_file_we <= 1'b0;
            o_file_addr <= 7'h00;
            o_file_data <= 8'h00;
            o_irq_control_we <= 1'b0;
            o_irq_control <= 8'h00;
            o_flush <= 1'b0;
        end else begin
            o_acc <= next_acc;
            o_program_counter <= next_prog_count;
            o_busy <= next_busy;
            o_pop <= next_pop;
            o_file_we <= next_fw.we;
            o_file_addr <= next_fw.addr;
            o_file_data <= next_fw.data;
            o_irq_control_we <= next_icw;
            o_irq_control <= next_ic;
            o_flush <= next_flush;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_store_writes_acc: assert property ( // see RQ1
        take && dec.op == OP_STORE
        |=> o_file_we
            && o_file_addr == $past(i_word[6:0])
            && o_file_data == $past(o_acc)
            && o_acc == $past(o_acc)
            && o_program_counter == $past(o_program_counter) + 13'h0001
            && !o_pop
            && !o_busy
    ) else $error("store wrong");

    a_load_sets_acc: assert property ( // see RQ2
        take && dec.op == OP_LOAD
        |=> o_acc == $past(i_word[7:0])
            && o_program_counter == $past(o_program_counter) + 13'h0001
            && !o_file_we
            && !o_pop
            && !o_busy
    ) else $error("load wrong");

    a_exit_pops_stack: assert property ( // see RQ3
        take && dec.op == OP_IRET
        |=> o_pop
            && o_flush
            && o_program_counter == $past(i_stack_top)
            && o_acc == $past(o_acc)
            && !o_file_we
    ) else $error("interrupt exit target wrong");

    a_exit_sets_enable: assert property ( // see RQ4
        take && dec.op == OP_IRET
        |=> o_irq_control_we
            && o_irq_control == ($past(i_irq_control) | (8'h01 << `IRQ_ENABLE_BIT))
            && o_busy
        ##1 !o_busy
    ) else $error("interrupt exit enable wrong");

    a_litret_loads: assert property ( // see RQ5
        take && dec.op == OP_LITRET
        |=> o_acc == $past(i_word[7:0])
            && o_program_counter == $past(i_stack_top)
            && o_pop
            && !o_irq_control_we
    ) else $error("literal return wrong");

    a_litret_two: assert property ( // see RQ6
        take && dec.op == OP_LITRET
        |=> o_busy && o_flush
        ##1 !o_busy && !o_flush
    ) else $error("literal return cycles wrong");

    a_return_pops_stack: assert property ( // see RQ7
        take && dec.op == OP_RET
        |=> o_program_counter == $past(i_stack_top)
            && o_acc == $past(o_acc)
            && o_pop
            && o_busy
            && !o_irq_control_we
        ##1 !o_busy
    ) else $error("return wrong");

    a_idle_advances: assert property ( // see RQ8
        take && dec.op == OP_NO_OPERATION
        |=> o_program_counter == $past(o_program_counter) + 13'h0001
            && o_acc == $past(o_acc)
            && !o_pop
            && !o_file_we
            && !o_irq_control_we
            && !o_busy
    ) else $error("no operation wrong");

    a_pop_only_once: assert property ( // see RQ7
        o_pop |=> !o_pop
    ) else $error("double pop");

    a_unknown_advances: assert property ( // see RQ8
        take && dec.op == OP_NONE
        |=> o_program_counter == $past(o_program_counter) + 13'h0001
            && o_acc == $past(o_acc)
            && !o_pop
            && !o_file_we
            && !o_busy
    ) else $error("unknown word wrong");

    a_busy_refuses: assert property ( // see RQ6
        o_busy
        |=> !o_busy
            && !o_pop
            && !o_file_we
            && !o_irq_control_we
            && o_acc == $past(o_acc)
            && o_program_counter == $past(o_program_counter)
    ) else $error("busy cycle not idle");

    a_pop_with_flush: assert property ( // see RQ6
        o_pop |-> o_flush && o_busy
    ) else $error("pop without flush");

    a_enable_needs_pop: assert property ( // see RQ4
        o_irq_control_we |-> o_pop && o_flush
    ) else $error("enable write outside exit");

    c_store: cover property (take && dec.op == OP_STORE);
    c_litret: cover property (take && dec.op == OP_LITRET ##2 take);
    c_iret: cover property (take && dec.op == OP_IRET);
    c_ret_then_load: cover property (take && dec.op == OP_RET ##2 take && dec.op == OP_LOAD);
    c_unknown: cover property (take && dec.op == OP_NONE);
endmodule : move_and_return_instruction_exec
`default_nettype wire

// [tb/move_and_return_instruction_exec_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "exec_params.svh"
module move_and_return_instruction_exec_tb;
    logic i_clk, i_rst, i_valid, o_busy, o_pop, o_file_we, o_irq_control_we, o_flush;
    logic [13:0] i_word;
    logic [12:0] i_stack_top, o_program_counter, prog_m;
    logic [7:0] i_irq_control, o_acc, o_file_data, o_irq_control, acc_m;
    logic [6:0] o_file_addr;
    integer seed;
    int n_mismatch, total_checks, cycles;
    int kind;
    logic [13:0] w_r;
    logic [12:0] t_r;
    logic [7:0] ic_r;
    move_and_return_instruction_exec dut (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid), .i_word(i_word),
        .i_stack_top(i_stack_top), .i_irq_control(i_irq_control), .o_acc(o_acc),
        .o_program_counter(o_program_counter), .o_busy(o_busy), .o_pop(o_pop), .o_file_we(o_file_we),
        .o_file_addr(o_file_addr), .o_file_data(o_file_data), .o_irq_control_we(o_irq_control_we),
        .o_irq_control(o_irq_control), .o_flush(o_flush));
    // ************************************
    // checking and closing
    // ************************************
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // accumulator, counter and the five pulses
    task chk_state(input logic [7:0] acc, input logic [12:0] prog, input logic [4:0] pulses);
        chk(32'({o_acc, o_program_counter, o_busy, o_pop, o_flush, o_file_we, o_irq_control_we}),
            32'({acc, prog, pulses}));
    endtask : chk_state
    task chk_file(input logic [6:0] addr, input logic [7:0] data);
        chk(32'({o_file_addr, o_file_data}), 32'({addr, data}));
    endtask : chk_file
    task chk_irq(input logic [7:0] exp);
        chk(32'(o_irq_control), 32'(exp));
    endtask : chk_irq
    function logic [7:0] exp_irq(input logic [7:0] ic);
        exp_irq = ic | (8'h01 << `IRQ_ENABLE_BIT);
    endfunction : exp_irq
    function logic [13:0] rnd_word(input int kind, input logic [7:0] r);
        case (kind)
            0: rnd_word = `OPC_NO_OPERATION;
            1: rnd_word = {`OPC_STORE_HI, r[6:0]};
            2: rnd_word = {`OPC_LOAD_HI, 2'b00, r};
            3: rnd_word = `OPC_RETURN;
            4: rnd_word = `OPC_INTERRUPT_EXIT;
            default: rnd_word = {`OPC_LITRET_HI, 2'b00, r};
        endcase
    endfunction : rnd_word
    // one instruction, then its dead cycle if it returns
    task exec(input logic [13:0] w, input logic [12:0] t, input logic [7:0] ic);
        logic st, ld, lr, ir, rt;
        st = w[13:7] == `OPC_STORE_HI;
        ld = w[13:10] == `OPC_LOAD_HI && w[9:8] == 2'h0;
        lr = w[13:10] == `OPC_LITRET_HI && w[9:8] == 2'h0;
        ir = w == `OPC_INTERRUPT_EXIT;
        rt = lr | ir | (w == `OPC_RETURN);
        i_valid = 1'b1;
        i_word = w;
        i_stack_top = t;
        i_irq_control = ic;
        @(posedge i_clk);
        #1;
        if (ld | lr) acc_m = w[7:0];
        prog_m = rt ? t : prog_m + 13'h0001;
        chk_state(acc_m, prog_m, {rt, rt, rt, st, ir});
        if (st) chk_file(w[6:0], acc_m);
        if (ir) chk_irq(exp_irq(ic));
        if (rt) begin
            i_word = {`OPC_LOAD_HI, 10'h0aa};
            @(posedge i_clk);
            #1;
            chk_state(acc_m, prog_m, 5'h00);
        end
    endtask : exec
    // ************************************
    // clock, watchdog, sequence
    // ************************************
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles > 4000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial begin
        seed = 32'h1fd5;
        i_rst = 1'b1;
        i_valid = 1'b0;
        i_word = 14'h0000;
        i_stack_top = 13'h0000;
        i_irq_control = 8'h00;
        acc_m = `ACC_RESET;
        prog_m = `PROG_COUNT_RESET;
        repeat (6) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        chk_state(`ACC_RESET, `PROG_COUNT_RESET, 5'h00);
        exec({`OPC_LOAD_HI, 10'h0ff}, 13'h0000, 8'h00);
        exec({`OPC_STORE_HI, 7'h7f}, 13'h0000, 8'h00);
        exec({`OPC_LITRET_HI, 10'h000}, 13'h1fff, 8'h00);
        exec(`OPC_INTERRUPT_EXIT, 13'h0123, 8'h00);
        exec(`OPC_RETURN, 13'h0abc, 8'h7f);
        exec(`OPC_NO_OPERATION, 13'h1555, 8'hff);
        exec(14'h31aa, 13'h0000, 8'h00);
        exec(14'h3fff, 13'h0000, 8'h00);
        repeat (300) begin
            kind = $unsigned($random(seed)) % 6;
            w_r = rnd_word(kind, 8'($random(seed)));
            t_r = 13'($random(seed));
            ic_r = 8'($random(seed));
            exec(w_r, t_r, ic_r);
        end
        // second reset in mid-run, then resume
        i_valid = 1'b0;
        i_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        acc_m = `ACC_RESET;
        prog_m = `PROG_COUNT_RESET;
        chk_state(`ACC_RESET, `PROG_COUNT_RESET, 5'h00);
        exec({`OPC_LOAD_HI, 10'h05a}, 13'h0000, 8'h00);
        exec(`OPC_RETURN, 13'h0042, 8'h00);
        i_valid = 1'b0;
        tally_and_finish;
    end
endmodule : move_and_return_instruction_exec_tb
`default_nettype wire
